/* File: hdl/pmcap_pkg.sv */
// Purpose: Shared constants and carrier types of the power-management capability block.
// Assumes: Configuration offsets are byte addresses; accesses are dword aligned.
// Notes:   Field positions refer to the 16-bit capability and control/status words.
package pmcap_pkg;

  // Configuration-space byte offsets.
  localparam logic [7:0] PTR_OFF   = 8'h34;
  localparam logic [7:0] HDR_OFF   = 8'h44;
  localparam logic [7:0] CAPS_OFF  = 8'h46;
  localparam logic [7:0] CSR_OFF   = 8'h48;
  localparam logic [7:0] EXT_OFF   = 8'h4a;
  localparam logic [7:0] DATA_OFF  = 8'h4b;

  // Fixed read values.
  localparam logic [7:0]  CAPABILITY_CODE = 8'h01;
  localparam logic [7:0]  NEXT_ITEM_PTR   = 8'h00;
  localparam logic [7:0]  BRIDGE_EXT_VAL  = 8'h00;
  localparam logic [7:0]  EMPTY_REPORT    = 8'h00;
  localparam logic [15:0] CAPS_RST        = 16'h7e02;
  // Only the wake-per-state and doze-support bits may be replaced by a load.
  localparam logic [15:0] CAPS_LOAD_MASK  = 16'h7e00;

  // Capabilities word fields.
  localparam int WAKE_FROM_COLD_OFF_BIT = 15;
  localparam int WAKE_FROM_FULL_ON_BIT  = 11;
  localparam int STANDBY_SUPPLY_LSB     = 6;

  // Control and status word fields.
  localparam int WAKE_STATUS_BIT  = 15;
  localparam int REPORT_SCALE_LSB = 13;
  localparam int REPORT_SEL_LSB   = 9;
  localparam int WAKE_ENABLE_BIT  = 8;
  localparam int LEVEL_LSB        = 0;

  localparam logic [1:0] LEVEL_FULL_ON = 2'h0;
  localparam logic [1:0] LEVEL_HOT_OFF = 2'h3;

  // Rating table geometry.
  localparam int RATING_DEPTH = 8;
  localparam int RATING_WIDTH = 10;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pmcap_cfg_req_t;

  typedef struct packed {
    logic        caps_vld;
    logic [15:0] caps;
    logic        rating_we;
    logic [2:0]  rating_idx;
    logic [7:0]  rating_val;
    logic [1:0]  rating_scale;
  } pmcap_load_t;

  typedef struct packed {
    logic [15:0] caps;
    logic        wake_status_flag;
    logic        wake_output_enable;
    logic [3:0]  report_sel;
    logic [1:0]  device_power_level;
    logic [31:0] rdata;
    logic        ack;
    logic        hot_exit;
  } pmcap_state_t;

  localparam pmcap_state_t STATE_RST = '{caps: CAPS_RST, default: '0};

endpackage

/* File: hdl/pmcap_rating_mem.sv */
// Purpose: Small table of power ratings with value and scale per entry.
// Assumes: One write port from the loader and one registered read port.
// Notes:   Entries clear to zero on reset; read data lag the index by one cycle.
`timescale 1ns/1ns
module pmcap_rating_mem #(
  parameter int DEPTH = pmcap_pkg::RATING_DEPTH,
  parameter int WIDTH = pmcap_pkg::RATING_WIDTH
) (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
  output logic      [WIDTH-1:0]         rd_data_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } pmcap_mem_state_t;

  pmcap_mem_state_t st_r;
  pmcap_mem_state_t st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.rd = st_r.mem[rd_idx_i];
    if (wr_en_i)
    begin
      st_nxt.mem[wr_idx_i] = wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o = st_r.rd;

endmodule

/* File: hdl/pmcap_top.sv */
// Purpose: Power-management capability structure in configuration space.
// Assumes: Config requests and loader strobes come from logic on clk_i.
// Notes:   Internal hot-exit reset never touches the control/status word.
// Notes on behaviour
// - Header low byte is read-only and returns capability code 01h.
// - Header high byte is read-only and returns 00h, no further item.
// - Capabilities word is read-only, resets to 7E02h, loader may override parts.
// - Loader can never set cold-off wake bit or standby supply field.
// - Bit 15 reads 0; bits 14 to 11 read 1 for wake support.
// - Bits 10 and 9 read 1, both doze levels supported.
// - Bits 5, 4 and 3 read 0.
// - Revision field in bits 2:0 reads 010b.
// - Internal reset on hot-off to full-on leaves control/status unchanged.
// - Bus reset returns every control/status bit to its reset value.
// - Wake status sets whenever wake would be asserted, ignoring the enable.
// - Writing 1 clears wake status and drops wake pin unless a wake event coincides; writing 0 does nothing.
// - Bit 8 gates the wake output; clear means wake never asserted.
// - Four-bit selector in bits 12:9 picks the reported rating, 0 to 7 valid.
// - Bits 14:13 report the scale of the selected rating.
// - Live report bit 4 and reserved bits 7:5, 3:2 read 0.
// - Bits 1:0 set and read back the power level D0 to D3.
// - Standby supply field always reads zero.
// - Selector values 8 to 15 report rating value 00h.
// - Capabilities pointer is read-only and returns 44h.
`timescale 1ns/1ns
module pmcap_top (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire pmcap_pkg::pmcap_cfg_req_t cfg_i,
  output logic      [31:0]             cfg_rdata_o,
  output logic                         cfg_ack_o,
  input  wire pmcap_pkg::pmcap_load_t  load_i,
  input  wire logic                    wake_event_i,
  output logic                         wake_pin_o,
  output logic                         wake_pin_oe_o,
  output logic      [1:0]              device_power_level_o,
  output logic                         hot_exit_rst_o
);

  pmcap_pkg::pmcap_state_t st_r;
  pmcap_pkg::pmcap_state_t st_nxt;
  logic [pmcap_pkg::RATING_WIDTH-1:0] rating_rd;
  logic [7:0]                         report_val;
  logic [1:0]                         report_scale;

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
    hits = (addr[7:2] == off[7:2]);
  endfunction

  function automatic logic [15:0] csr_word(input pmcap_pkg::pmcap_state_t s, input logic [1:0] scale);
    csr_word                                  = '0;
    csr_word[pmcap_pkg::WAKE_STATUS_BIT]      = s.wake_status_flag;
    csr_word[pmcap_pkg::REPORT_SCALE_LSB+:2]  = scale;
    csr_word[pmcap_pkg::REPORT_SEL_LSB+:4]    = s.report_sel;
    csr_word[pmcap_pkg::WAKE_ENABLE_BIT]      = s.wake_output_enable;
    csr_word[pmcap_pkg::LEVEL_LSB+:2]         = s.device_power_level;
  endfunction

  pmcap_rating_mem #(
    .DEPTH (pmcap_pkg::RATING_DEPTH),
    .WIDTH (pmcap_pkg::RATING_WIDTH)
  ) u_rating (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (load_i.rating_we),
    .wr_idx_i  (load_i.rating_idx),
    .wr_data_i ({load_i.rating_scale, load_i.rating_val}),
    .rd_idx_i  (st_r.report_sel[2:0]),
    .rd_data_o (rating_rd)
  );

  // Selector values 8 to 15 are reserved and report nothing.
  always_comb
  begin
    if (st_r.report_sel[3])
    begin
      report_val   = pmcap_pkg::EMPTY_REPORT;
      report_scale = 2'h0;
    end
    else
    begin
      report_val   = rating_rd[7:0];
      report_scale = rating_rd[9:8];
    end
  end

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.ack      = cfg_i.req;
    st_nxt.hot_exit = 1'b0;
    st_nxt.rdata    = '0;

    if (load_i.caps_vld)
    begin
      // Bits outside the mask keep their fixed values, so cold-off wake and standby supply stay zero.
      st_nxt.caps = (pmcap_pkg::CAPS_RST & ~pmcap_pkg::CAPS_LOAD_MASK)
                  | (load_i.caps & pmcap_pkg::CAPS_LOAD_MASK);
    end

    if (cfg_i.req && !cfg_i.we)
    begin
      if (hits(cfg_i.addr, pmcap_pkg::PTR_OFF))
      begin
        st_nxt.rdata = {24'h000000, pmcap_pkg::HDR_OFF};
      end
      else if (hits(cfg_i.addr, pmcap_pkg::HDR_OFF))
      begin
        st_nxt.rdata = {st_r.caps, pmcap_pkg::NEXT_ITEM_PTR, pmcap_pkg::CAPABILITY_CODE};
      end
      else if (hits(cfg_i.addr, pmcap_pkg::CSR_OFF))
      begin
        st_nxt.rdata = {report_val, pmcap_pkg::BRIDGE_EXT_VAL, csr_word(st_r, report_scale)};
      end
    end

    // Only enable, selector, level and the status clear are writable; all else drops.
    if (cfg_i.req && cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF))
    begin
      if (cfg_i.be[0])
      begin
        st_nxt.device_power_level = cfg_i.wdata[pmcap_pkg::LEVEL_LSB+:2];
        st_nxt.hot_exit = (st_r.device_power_level == pmcap_pkg::LEVEL_HOT_OFF)
                       && (cfg_i.wdata[pmcap_pkg::LEVEL_LSB+:2] == pmcap_pkg::LEVEL_FULL_ON);
      end
      if (cfg_i.be[1])
      begin
        st_nxt.wake_output_enable = cfg_i.wdata[pmcap_pkg::WAKE_ENABLE_BIT];
        st_nxt.report_sel         = cfg_i.wdata[pmcap_pkg::REPORT_SEL_LSB+:4];
        if (cfg_i.wdata[pmcap_pkg::WAKE_STATUS_BIT])
        begin
          st_nxt.wake_status_flag = 1'b0;
        end
      end
    end

    // A wake event in the clearing cycle wins, so it is never lost.
    if (wake_event_i && st_r.caps[pmcap_pkg::WAKE_FROM_FULL_ON_BIT + int'(st_r.device_power_level)])
    begin
      st_nxt.wake_status_flag = 1'b1;
    end
  end

  // Only the bus reset clears this state; the hot-exit pulse goes elsewhere.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= pmcap_pkg::STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_o          = st_r.rdata;
  assign cfg_ack_o            = st_r.ack;
  assign wake_pin_o           = 1'b0;
  assign wake_pin_oe_o        = st_r.wake_status_flag & st_r.wake_output_enable;
  assign device_power_level_o = st_r.device_power_level;
  assign hot_exit_rst_o       = st_r.hot_exit;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_hdr_code_read:   assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::HDR_OFF)
                       |=> cfg_ack_o && cfg_rdata_o[7:0] == 8'h01)
    else $error("capability code wrong");
  a_next_ptr_read:   assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::HDR_OFF)
                       |=> cfg_rdata_o[15:8] == 8'h00)
    else $error("next pointer not zero");
  a_caps_fixed_bits: assert property ((st_r.caps & 16'h81ff) == 16'h0002)
    else $error("fixed capability bits changed");
  a_wake_sets_flag:  assert property (wake_event_i && device_power_level_o == 2'h0 && st_r.caps[11]
                       |=> st_r.wake_status_flag)
    else $error("wake status not set");
  a_wake_clear_one:  assert property (cfg_i.req && cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && cfg_i.be[1] && cfg_i.wdata[15] && !wake_event_i |=> !wake_pin_oe_o)
    else $error("wake not cleared");
  a_wake_gated:      assert property (!st_r.wake_output_enable |-> !wake_pin_oe_o)
    else $error("wake driven while disabled");
  a_level_written:   assert property (cfg_i.req && cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && cfg_i.be[0] |=> device_power_level_o == $past(cfg_i.wdata[1:0]))
    else $error("power level not written");
  a_csr_reserved:    assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       |=> cfg_rdata_o[7:2] == 6'h00)
    else $error("reserved bits nonzero");
  a_sel_high_empty:  assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && st_r.report_sel[3] |=> cfg_rdata_o[31:24] == 8'h00 && cfg_rdata_o[14:13] == 2'h0)
    else $error("reserved selector reported data");
  a_ptr_read:        assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::PTR_OFF)
                       |=> cfg_rdata_o == 32'h00000044)
    else $error("capability pointer wrong");
  a_hot_exit_keep:   assert property (hot_exit_rst_o && !cfg_i.req && !wake_event_i
                       |=> $stable(st_r.wake_output_enable) && $stable(st_r.wake_status_flag))
    else $error("hot exit changed control word");
  a_bus_rst_clear:   assert property (disable iff (1'b0) sys_rst_i
                       |=> device_power_level_o == 2'h0 && !wake_pin_oe_o && !st_r.wake_output_enable)
    else $error("bus reset left state");

  // Capabilities word: fixed fields survive any loader image; reset value, read data and write protection.
  a_cold_wake_zero:  assert property (!st_r.caps[pmcap_pkg::WAKE_FROM_COLD_OFF_BIT])
    else $error("cold-off wake bit set");
  a_standby_zero:    assert property (st_r.caps[8:6] == 3'h0)
    else $error("standby supply field nonzero");
  a_caps_low_zero:   assert property (st_r.caps[5:3] == 3'h0)
    else $error("capability bits 5 to 3 nonzero");
  a_caps_revision:   assert property (st_r.caps[2:0] == 3'h2)
    else $error("revision field wrong");
  a_caps_rst_value:  assert property (disable iff (1'b0) sys_rst_i |=> st_r.caps == 16'h7e02)
    else $error("capability reset value wrong");
  a_caps_read_data:  assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::HDR_OFF)
                       && !load_i.caps_vld |=> cfg_rdata_o[31:16] == st_r.caps)
    else $error("capability word read wrong");
  a_ro_write_keep:   assert property (cfg_i.req && cfg_i.we && !hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && !load_i.caps_vld |=> $stable(st_r.caps))
    else $error("read-only write took effect");

  // Control and status word behaviour.
  a_sel_written:     assert property (cfg_i.req && cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && cfg_i.be[1] |=> st_r.report_sel == $past(cfg_i.wdata[12:9]))
    else $error("selector not written");
  a_scale_read:      assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && !st_r.report_sel[3] |=> cfg_rdata_o[14:13] == $past(rating_rd[9:8]))
    else $error("scale of selected rating wrong");
  a_csr_ext_zero:    assert property (cfg_i.req && !cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       |=> cfg_rdata_o[23:16] == 8'h00 && !cfg_rdata_o[4])
    else $error("bridge byte or live flag nonzero");
  a_zero_write_keep: assert property (cfg_i.req && cfg_i.we && hits(cfg_i.addr, pmcap_pkg::CSR_OFF)
                       && st_r.wake_status_flag && !cfg_i.wdata[15] |=> st_r.wake_status_flag)
    else $error("writing 0 cleared wake status");
  a_flag_needs_evt:  assert property (!wake_event_i && !st_r.wake_status_flag |=> !st_r.wake_status_flag)
    else $error("wake status set without event");
  a_hot_exit_pulse:  assert property (hot_exit_rst_o
                       |-> $past(device_power_level_o) == 2'h3 && device_power_level_o == 2'h0)
    else $error("hot exit without level change");
  a_pin_level_low:   assert property (!wake_pin_o)
    else $error("wake pin value not low");

  // Every request is answered one cycle later, and only then.
  a_ack_follows:     assert property (cfg_i.req |=> cfg_ack_o)
    else $error("request not acknowledged");
  a_ack_only_req:    assert property (!cfg_i.req |=> !cfg_ack_o)
    else $error("acknowledge without request");
  a_rdata_idle:      assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h00000000)
    else $error("read data outside answer");

  c_wake_driven:  cover property (wake_event_i ##1 wake_pin_oe_o);
  c_sel_reserved: cover property (cfg_i.req && !cfg_i.we && st_r.report_sel[3]);
  c_hot_exit:     cover property (hot_exit_rst_o);
  c_caps_load:    cover property (load_i.caps_vld ##1 st_r.caps != pmcap_pkg::CAPS_RST);
  c_set_on_clear: cover property (wake_event_i && cfg_i.req && cfg_i.we && cfg_i.wdata[15] && cfg_i.be[1]);

endmodule

/* File: verif/pmcap_host_model.sv */
// Purpose: Host bridge model issuing one configuration cycle at a time.
// Assumes: The block answers every request one cycle after it is taken.
// Notes:   Released request lines carry the inverse of the last value.
`timescale 1ns/1ns
module pmcap_host_model (
  input  wire logic                 clk_i,
  output pmcap_pkg::pmcap_cfg_req_t cfg_o
);
  initial cfg_o = '0;

  // Level writes and write-one status clears travel through this task.
  task automatic access(input logic we, input logic [7:0] addr,
                        input logic [3:0] be, input logic [31:0] wdata);
    @(posedge clk_i);
    cfg_o <= '{req: 1'b1, we: we, addr: addr, be: be, wdata: wdata};
    @(posedge clk_i);
    cfg_o <= '{req: 1'b0, we: ~we, addr: ~addr, be: ~be, wdata: ~wdata};
  endtask
endmodule

/* File: verif/tb.sv */
// Purpose: Self-checking bench of the power-management capability block.
// Assumes: Expected read data are queued in request order.
// Notes:   Writes answer with zero read data.
`timescale 1ns/1ns
module tb;
  logic                      clk_i = 1'b0;
  logic                      sys_rst_i = 1'b1;
  pmcap_pkg::pmcap_cfg_req_t cfg;
  pmcap_pkg::pmcap_load_t    load = '0;
  logic                      wake_event_i = 1'b0;
  logic [31:0]               cfg_rdata_o;
  logic                      cfg_ack_o;
  logic                      wake_pin_o;
  logic                      wake_pin_oe_o;
  logic                      hot_exit_rst_o;
  logic [1:0]                device_power_level_o;
  logic [31:0]               exp_q[$];
  logic [15:0]               rnd = 16'h004b;
  logic [7:0]                rval[8];
  logic [1:0]                rscl[8];
  int                        bad_count = 0;
  int                        num_checks = 0;

  pmcap_host_model u_pmcap_host_model (.clk_i(clk_i), .cfg_o(cfg));
  pmcap_top u_pmcap_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg),
    .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .load_i(load),
    .wake_event_i(wake_event_i), .wake_pin_o(wake_pin_o), .wake_pin_oe_o(wake_pin_oe_o),
    .device_power_level_o(device_power_level_o), .hot_exit_rst_o(hot_exit_rst_o));

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_pmcap_host_model.access(1'b0, a, 4'hf, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    exp_q.push_back(32'h0);
    u_pmcap_host_model.access(1'b1, a, be, d);
  endtask

  task automatic wake_pulse();
    @(posedge clk_i);
    wake_event_i <= 1'b1;
    @(posedge clk_i);
    wake_event_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // An answer with nothing queued is forced to mismatch.
  always @(posedge clk_i)
    if (cfg_ack_o === 1'b1)
      chk(cfg_rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : ~cfg_rdata_o);

  initial
  begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h34, 32'h0000_0044);
    rd(8'h44, 32'h7e02_0001);
    rd(8'h48, 32'h0);
    wr(8'h34, 4'hf, 32'hffff_ffff);
    wr(8'h44, 4'hf, 32'hffff_ffff);
    wr(8'h48, 4'hc, 32'hffff_ffff);
    rd(8'h34, 32'h0000_0044);
    rd(8'h44, 32'h7e02_0001);
    rd(8'h48, 32'h0);
    wr(8'h48, 4'h2, 32'h100);
    for (int l = 0; l < 4; l++)
    begin
      wr(8'h48, 4'h1, 32'(l));
      rd(8'h48, 32'h100 | 32'(l));
      chk(32'(device_power_level_o), 32'(l));
    end
    wr(8'h48, 4'h1, 32'h0);
    #1;
    chk(32'(hot_exit_rst_o), 32'h1);
    rd(8'h48, 32'h100);
    wr(8'h48, 4'h2, 32'h0);
    wake_pulse();
    chk(32'(wake_pin_oe_o), 32'h0);
    chk(32'(wake_pin_o), 32'h0);
    rd(8'h48, 32'h8000);
    wr(8'h48, 4'h2, 32'h100);
    #1;
    chk(32'(wake_pin_oe_o), 32'h1);
    rd(8'h48, 32'h8100);
    wr(8'h48, 4'h2, 32'h8100);
    #1;
    chk(32'(wake_pin_oe_o), 32'h0);
    rd(8'h48, 32'h100);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      rval[i] = rnd[7:0];
      rscl[i] = rnd[9:8];
      @(posedge clk_i);
      load <= '{rating_we: 1'b1, rating_idx: 3'(i), rating_val: rnd[7:0], rating_scale: rnd[9:8], default: '0};
    end
    @(posedge clk_i);
    load <= '0;
    for (int s = 0; s < 16; s++)
    begin
      wr(8'h48, 4'h2, {19'h0, 4'(s), 9'h100});
      rd(8'h48, {s < 8 ? rval[s % 8] : 8'h0, 9'h0, s < 8 ? rscl[s % 8] : 2'h0, 4'(s), 9'h100});
    end
    rnd = lfsr(rnd);
    @(posedge clk_i);
    load <= '{caps_vld: 1'b1, caps: rnd | 16'h81c0, default: '0};
    @(posedge clk_i);
    load <= '0;
    rd(8'h44, {(rnd & 16'h7e00) | 16'h0002, 16'h0001});
    wr(8'h48, 4'h1, 32'h2);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h48, 32'h0);
    rd(8'h44, 32'h7e02_0001);
    chk(32'(device_power_level_o), 32'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule
